// ===== shared/atm_pkg.sv
package atm_pkg;
    // ---------------------------------------------------------------
    // multiplex m-frame layout
    // ---------------------------------------------------------------
    localparam int M_SUBS = 7;
    localparam int M_BLKS = 8;
    localparam int M_INFO = 84;
    localparam int M_TRIBS = 7;
    localparam logic [2:0] M_LAST_SUB = 3'h6;
    localparam logic [2:0] M_LAST_BLK = 3'h7;
    localparam logic [6:0] M_LAST_POS = 7'h54;
    localparam logic [2:0] M_LAST_TRIB = 3'h6;
    localparam logic [2:0] M_ALIGN_BASE = 3'h4;
    // subframe alignment bits 0,1,0 indexed from subframe 4
    localparam logic [2:0] M_ALIGN = 3'h2;
    // f1..f4 = 1,0,0,1 indexed by block / 2
    localparam logic [3:0] M_FBITS = 4'h9;
    // ---------------------------------------------------------------
    // four-set merge frame layout
    // ---------------------------------------------------------------
    localparam int E_TRIBS = 4;
    localparam int E_MID_SET_LEN = 212;
    localparam int E_TOP_SET_LEN = 384;
    localparam int E_MID_COUNT = 4;
    localparam logic [9:0] E_FRAME_ALIGN = 10'h3d0;
    localparam logic [8:0] E_FRAME_ALIGN_LEN = 9'h00a;
    localparam logic [3:0] E_FRAME_ALIGN_TOP = 4'h9;
    localparam logic [8:0] E_ALARM_POS = 9'h00a;
    localparam logic [8:0] E_NAT_POS = 9'h00b;
    localparam logic [8:0] E_CTL_LEN = 9'h004;
    localparam logic [8:0] E_STUFF_END = 9'h008;
    localparam logic STUFF_FILL = 1'b1;

    typedef enum logic [1:0]
    {
        SET1 = 2'b00,
        SET2 = 2'b01,
        SET3 = 2'b10,
        SET4 = 2'b11
    } atm_set_t;
endpackage

// ===== rtl/atm_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module atm_buf2
    import atm_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } atm_buf_t;

    atm_buf_t s;
    atm_buf_t next_s;
    logic push;
    logic pop;

    // two entries let the writer keep going for one cycle after a stall
    assign in_ready = (s.cnt != 2'h2);
    assign out_valid = (s.cnt != 2'h0);
    assign out_data = s.mem[s.rd];

    always_comb
    begin
        next_s = s;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = ~s.wr;
        end
        if (pop)
            next_s.rd = ~s.rd;
        if (push && !pop)
            next_s.cnt = s.cnt + 2'h1;
        else if (pop && !push)
            next_s.cnt = s.cnt - 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end
endmodule
`default_nettype wire

// ===== rtl/atm_eframe.sv
`timescale 1ns/100ps
`default_nettype none
module atm_eframe
    import atm_pkg::*;
#(
    parameter int SET_LEN = E_MID_SET_LEN
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] trib_valid,
    input wire logic [3:0] trib_bit,
    output logic [3:0] trib_ready,
    input wire logic [3:0] stuff_req,
    input wire logic alarm_bit,
    input wire logic nat_bit,
    output logic out_valid,
    output logic out_bit,
    input wire logic out_ready
);
    typedef struct packed {
        atm_set_t set;
        logic [8:0] pos;
        logic [1:0] trib;
        logic [3:0] stuff;
        logic obit;
        logic ovld;
    } atm_ef_t;

    atm_ef_t s;
    atm_ef_t next_s;
    logic adv;
    logic is_data;
    logic interleaved;
    logic slot_bit;
    logic [1:0] src;
    logic [3:0] align_idx;
    logic ctl_bit;

    assign out_valid = s.ovld;
    assign out_bit = s.obit;
    assign align_idx = E_FRAME_ALIGN_TOP - s.pos[3:0];
    assign ctl_bit = s.stuff[s.pos[1:0]];

    // ---------------------------------------------------------------
    // slot decode and sequencing
    // ---------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        is_data = 1'b0;
        interleaved = 1'b0;
        src = s.trib;
        slot_bit = STUFF_FILL;
        if (s.set == SET1 && s.pos < E_FRAME_ALIGN_LEN)
            slot_bit = E_FRAME_ALIGN[align_idx]; // see R10
        else if (s.set == SET1 && s.pos == E_ALARM_POS)
            slot_bit = alarm_bit; // see R10
        else if (s.set == SET1 && s.pos == E_NAT_POS)
            slot_bit = nat_bit; // see R10
        else if (s.set != SET1 && s.pos < E_CTL_LEN)
            slot_bit = s.stuff[s.pos[1:0]]; // see R12, R17
        else if (s.set == SET4 && s.pos < E_STUFF_END)
        begin
            src = s.pos[1:0]; // see R13, R17
            is_data = !s.stuff[src]; // see R14, R15
        end
        else
        begin
            is_data = 1'b1; // see R11
            interleaved = 1'b1;
        end
        if (is_data)
            slot_bit = trib_bit[src];
        // a missing tributary bit stalls the frame rather than corrupting it
        adv = (!s.ovld || out_ready) && (!is_data || trib_valid[src]);
        trib_ready = (is_data && adv) ? (4'h1 << src) : 4'h0;
        if (s.ovld && out_ready)
            next_s.ovld = 1'b0;
        if (adv)
        begin
            next_s.obit = slot_bit;
            next_s.ovld = 1'b1;
            if (interleaved)
                next_s.trib = s.trib + 2'h1; // see R11
            if (s.pos == 9'(SET_LEN - 1))
            begin
                next_s.pos = '0; // see R9
                next_s.trib = '0;
                next_s.set = atm_set_t'(s.set + 2'h1);
                if (s.set == SET4)
                    next_s.stuff = stuff_req;
            end
            else
                next_s.pos = s.pos + 9'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_E_SET_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        adv && s.pos == 9'(SET_LEN - 1)
        |=> s.pos == 9'h000 && s.set == atm_set_t'($past(s.set) + 2'h1))
        else $error("set did not wrap at its length");
    AST_E_ALIGN: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        adv && s.set == SET1 && s.pos < E_FRAME_ALIGN_LEN
        |=> out_bit == E_FRAME_ALIGN[$past(align_idx)])
        else $error("alignment pattern bit wrong");
    AST_E_TRIB1: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        adv && s.set == SET1 && s.pos == E_NAT_POS + 9'h001 |-> trib_ready == 4'h1)
        else $error("first data bit not from tributary 1");
    AST_E_CTL: assert property (@(posedge clk) disable iff (!rst_n) // see R12, R17
        adv && s.set != SET1 && s.pos < E_CTL_LEN
        |-> trib_ready == 4'h0 ##1 out_bit == $past(ctl_bit))
        else $error("control bit wrong");
    AST_E_STUFF: assert property (@(posedge clk) disable iff (!rst_n) // see R13, R15
        adv && s.set == SET4 && s.pos >= E_CTL_LEN && s.pos < E_STUFF_END
        && s.stuff[s.pos[1:0]] |-> trib_ready == 4'h0 ##1 out_bit == STUFF_FILL)
        else $error("stuffed position carried data");
    AST_E_JUST: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        adv && s.set == SET4 && s.pos >= E_CTL_LEN && s.pos < E_STUFF_END
        && !s.stuff[s.pos[1:0]] |-> trib_ready == (4'h1 << s.pos[1:0]))
        else $error("unstuffed position lost data");
endmodule
`default_nettype wire

// ===== rtl/atm_mux.sv
// Behaviour
// R1 - seven subframes, eight blocks, 1+84 bits
// R2 - overhead order X,X,P,P,0,1,0 then F/C
// R3 - stuff slot at bit n after F4
// R4 - c bits one means stuff bit
// R5 - info bits interleave seven tributaries, 1 first
// R6 - sixteen tributaries merged in two stages
// R7 - four per mid stream, four mids top
// R8 - both merge stages run independently
// R9 - four sets cycle 1,2,3,4
// R10 - set 1: pattern, alarm, national bit
// R11 - data interleaved, tributary 1 first
// R12 - first four bits of sets 2-4 control
// R13 - set 4 bits 5-8 stuff positions
// R14 - majority zero: stuff position carries data
// R15 - majority one: stuff position carries none
// R16 - top frame same layout, 384-bit sets
// R17 - control bit j, bit 4+j: tributary j
`timescale 1ns/100ps
`default_nettype none
module atm_mux
    import atm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] m_trib_valid,
    input wire logic [6:0] m_trib_bit,
    output logic [6:0] m_trib_ready,
    input wire logic [6:0] m_stuff_req,
    input wire logic m_alarm,
    input wire logic m_parity,
    output logic m_line_valid,
    output logic m_line_bit,
    input wire logic m_line_ready,
    input wire logic [15:0] e_trib_valid,
    input wire logic [15:0] e_trib_bit,
    output logic [15:0] e_trib_ready,
    input wire logic [15:0] e_stuff_req_mid,
    input wire logic [3:0] e_stuff_req_top,
    input wire logic e_mid_alarm,
    input wire logic e_mid_nat,
    input wire logic e_top_alarm,
    input wire logic e_top_nat,
    output logic e_line_valid,
    output logic e_line_bit,
    input wire logic e_line_ready
);
    // ---------------------------------------------------------------
    // m-frame state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sub;
        logic [2:0] blk;
        logic [6:0] pos;
        logic [2:0] trib;
        logic [6:0] stuff;
        logic obit;
        logic ovld;
    } atm_mf_t;

    atm_mf_t s;
    atm_mf_t next_s;
    logic adv;
    logic is_data;
    logic stuffed;
    logic slot_bit;
    logic buf_ready;

    // ---------------------------------------------------------------
    // slot decode
    // ---------------------------------------------------------------
    // the opportunity rides on that tributary's own interleave slot
    function automatic logic stuff_slot
    (
        input logic [2:0] blk,
        input logic [2:0] sub,
        input logic [6:0] pos
    );
        return blk == M_LAST_BLK && pos == {4'h0, sub} + 7'h01; // see R3
    endfunction

    always_comb
    begin
        next_s = s;
        is_data = 1'b0;
        stuffed = 1'b0;
        slot_bit = STUFF_FILL;
        if (s.pos == 7'h00)
        begin
            if (s.blk == 3'h0)
            begin
                if (s.sub < 3'h2)
                    slot_bit = m_alarm; // see R2
                else if (s.sub < M_ALIGN_BASE)
                    slot_bit = m_parity; // see R2
                else
                    slot_bit = M_ALIGN[s.sub[1:0]]; // see R2
            end
            else if (s.blk[0])
                slot_bit = M_FBITS[s.blk[2:1]]; // see R2
            else
                slot_bit = s.stuff[s.sub]; // see R2, R4
        end
        else
        begin
            stuffed = stuff_slot(s.blk, s.sub, s.pos) && s.stuff[s.sub]; // see R3, R4
            is_data = !stuffed;
            if (is_data)
                slot_bit = m_trib_bit[s.trib]; // see R5
        end
        adv = (!s.ovld || buf_ready) && (!is_data || m_trib_valid[s.trib]);
        m_trib_ready = (is_data && adv) ? (7'h01 << s.trib) : 7'h00;
        if (s.ovld && buf_ready)
            next_s.ovld = 1'b0;
        if (adv)
        begin
            next_s.obit = slot_bit;
            next_s.ovld = 1'b1;
            if (s.pos != 7'h00)
                next_s.trib = (s.trib == M_LAST_TRIB) ? 3'h0 : s.trib + 3'h1; // see R5
            if (s.pos == M_LAST_POS)
            begin
                next_s.pos = '0; // see R1
                next_s.trib = '0;
                if (s.blk == M_LAST_BLK)
                begin
                    next_s.blk = '0;
                    if (s.sub == M_LAST_SUB)
                    begin
                        next_s.sub = '0; // see R1
                        next_s.stuff = m_stuff_req;
                    end
                    else
                        next_s.sub = s.sub + 3'h1;
                end
                else
                    next_s.blk = s.blk + 3'h1;
            end
            else
                next_s.pos = s.pos + 7'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ---------------------------------------------------------------
    // line buffers
    // ---------------------------------------------------------------
    atm_buf2 #(.WIDTH(1)) u_m_buf
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(s.ovld),
        .in_data(s.obit),
        .in_ready(buf_ready),
        .out_valid(m_line_valid),
        .out_data(m_line_bit),
        .out_ready(m_line_ready)
    );

    // ---------------------------------------------------------------
    // two-stage merge
    // ---------------------------------------------------------------
    logic [3:0] mid_valid;
    logic [3:0] mid_bit;
    logic [3:0] mid_ready;
    logic [3:0] top_valid;
    logic [3:0] top_bit;
    logic [3:0] top_ready;
    logic top_out_valid;
    logic top_out_bit;
    logic top_out_ready;

    // each stage keeps its own counters; buffers decouple them
    for (genvar g = 0; g < E_MID_COUNT; g++)
    begin : g_mid
        atm_eframe #(.SET_LEN(E_MID_SET_LEN)) u_mid // see R6, R7, R8
        (
            .clk(clk),
            .rst_n(rst_n),
            .trib_valid(e_trib_valid[4*g +: 4]),
            .trib_bit(e_trib_bit[4*g +: 4]),
            .trib_ready(e_trib_ready[4*g +: 4]),
            .stuff_req(e_stuff_req_mid[4*g +: 4]),
            .alarm_bit(e_mid_alarm),
            .nat_bit(e_mid_nat),
            .out_valid(mid_valid[g]),
            .out_bit(mid_bit[g]),
            .out_ready(mid_ready[g])
        );

        atm_buf2 #(.WIDTH(1)) u_mid_buf
        (
            .clk(clk),
            .rst_n(rst_n),
            .in_valid(mid_valid[g]),
            .in_data(mid_bit[g]),
            .in_ready(mid_ready[g]),
            .out_valid(top_valid[g]),
            .out_data(top_bit[g]),
            .out_ready(top_ready[g])
        );

        AST_E_MID_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see R8
            mid_valid[g] && !mid_ready[g] |=> mid_valid[g] && $stable(mid_bit[g]))
            else $error("mid stream bit changed while stalled");
        AST_E_MID_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // see R11
            $onehot0(e_trib_ready[4*g +: 4]))
            else $error("more than one lowest tributary taken at once");
    end

    atm_eframe #(.SET_LEN(E_TOP_SET_LEN)) u_top // see R7, R16
    (
        .clk(clk),
        .rst_n(rst_n),
        .trib_valid(top_valid),
        .trib_bit(top_bit),
        .trib_ready(top_ready),
        .stuff_req(e_stuff_req_top),
        .alarm_bit(e_top_alarm),
        .nat_bit(e_top_nat),
        .out_valid(top_out_valid),
        .out_bit(top_out_bit),
        .out_ready(top_out_ready)
    );

    atm_buf2 #(.WIDTH(1)) u_top_buf
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(top_out_valid),
        .in_data(top_out_bit),
        .in_ready(top_out_ready),
        .out_valid(e_line_valid),
        .out_data(e_line_bit),
        .out_ready(e_line_ready)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_M_BLOCK: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        adv && s.pos == M_LAST_POS |=> s.pos == 7'h00 && s.trib == 3'h0)
        else $error("block did not end after 84 info bits");
    AST_M_FRAME: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        adv && s.pos == M_LAST_POS && s.blk == M_LAST_BLK && s.sub == M_LAST_SUB
        |=> s.sub == 3'h0 && s.blk == 3'h0 && s.stuff == $past(m_stuff_req))
        else $error("m-frame did not wrap after seven subframes");
    AST_M_XFIRST: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        adv && s.pos == 7'h00 && s.blk == 3'h0 && s.sub == 3'h0
        |=> s.obit == $past(m_alarm))
        else $error("first overhead bit is not the alarm bit");
    AST_M_F4: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        adv && s.pos == 7'h00 && s.blk == M_LAST_BLK |=> s.obit == 1'b1)
        else $error("f4 overhead bit not one");
    AST_M_STUFF: assert property (@(posedge clk) disable iff (!rst_n) // see R3, R4
        adv && stuff_slot(s.blk, s.sub, s.pos) && s.stuff[s.sub]
        |-> m_trib_ready == 7'h00 ##1 s.obit == STUFF_FILL)
        else $error("stuff slot carried tributary data");
    AST_M_INTERLEAVE: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        adv && s.pos == 7'h01 && !(s.blk == M_LAST_BLK && s.sub == 3'h0 && s.stuff[0])
        |-> m_trib_ready == 7'h01)
        else $error("block info does not start with tributary 1");
    AST_M_ALIGN: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        adv && s.pos == 7'h00 && s.blk == 3'h0 && s.sub >= M_ALIGN_BASE
        |=> s.obit == ($past(s.sub) == 3'h5))
        else $error("subframe alignment bit wrong");
    AST_M_PARITY: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        adv && s.pos == 7'h00 && s.blk == 3'h0 && s.sub[2:1] == 2'h1
        |=> s.obit == $past(m_parity))
        else $error("parity overhead bit wrong");
    AST_M_FZERO: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        adv && s.pos == 7'h00 && (s.blk == 3'h3 || s.blk == 3'h5)
        |=> s.obit == 1'b0)
        else $error("f2 or f3 overhead bit not zero");
    AST_M_CBITS: assert property (@(posedge clk) disable iff (!rst_n) // see R2, R4
        adv && s.pos == 7'h00 && s.blk != 3'h0 && !s.blk[0]
        |=> s.obit == s.stuff[s.sub])
        else $error("c bit does not carry the stuff decision");
    AST_M_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        $onehot0(m_trib_ready))
        else $error("more than one tributary taken at once");
    AST_M_GAP: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        is_data && !m_trib_valid[s.trib] |-> m_trib_ready == 7'h00 && !adv)
        else $error("slot advanced without its tributary bit");
    AST_M_OH_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        s.pos == 7'h00 |-> m_trib_ready == 7'h00)
        else $error("overhead slot took a tributary bit");
    AST_M_LINE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        m_line_valid && !m_line_ready
        |=> m_line_valid && $stable(m_line_bit))
        else $error("m line bit changed while stalled");

    // ---------------------------------------------------------------
    // merge checks
    // ---------------------------------------------------------------
    AST_E_LINE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        e_line_valid && !e_line_ready
        |=> e_line_valid && $stable(e_line_bit))
        else $error("top line bit changed while stalled");
endmodule
`default_nettype wire

// ===== tb/atm_line_sink.sv
`timescale 1ns/100ps
`default_nettype none
module atm_line_sink
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic [15:0] limit,
    input wire logic line_valid,
    input wire logic line_bit,
    output logic line_ready
);
    // ---------------------------------------------------------------
    // aggregate line sink
    // ---------------------------------------------------------------
    logic [1:0] phase;
    logic [15:0] cnt;
    logic got[$];
    // stops at limit so the upstream buffers fill and must refuse
    // ready comes from registers only, so it never moves inside a clock edge
    always_comb
    begin
        line_ready = rst_n && (cnt < limit) && !(stall && phase == 2'h3);
    end
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase <= 2'h0;
            cnt <= 16'h0000;
            got.delete();
        end
        else
        begin
            phase <= phase + 2'h1;
            if (line_valid && line_ready)
            begin
                cnt <= cnt + 16'h0001;
                got.push_back(line_bit);
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_async_tributary_mux_framing.sv
`timescale 1ns/100ps
`default_nettype none
module test_async_tributary_mux_framing;
    import atm_pkg::*;
    typedef struct {
        logic [6:0] ms; logic ma; logic mp; logic [3:0] eb; logic [3:0] em;
        logic [3:0] et; logic ea; logic en; logic gap; int taken;
    } atm_row_t;
    localparam logic [6:0] MB = 7'h59;
    atm_row_t rows[3] = '{
        '{7'h00, 1'b1, 1'b0, 4'ha, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0, 9408},
        '{7'h7f, 1'b0, 1'b1, 4'h5, 4'hf, 4'hf, 1'b0, 1'b1, 1'b1, 9401},
        '{7'h25, 1'b1, 1'b1, 4'hc, 4'h6, 4'h9, 1'b1, 1'b1, 1'b1, 9405}};
    atm_row_t cur = '{7'h00, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] m_trib_valid = 7'h00;
    logic [15:0] e_trib_valid = 16'h0000;
    logic [6:0] m_bits = MB;
    logic [6:0] m_tog = 7'h00;
    logic [6:0] m_trib_ready;
    logic [15:0] e_trib_ready;
    logic m_line_valid, m_line_bit, m_line_ready, e_line_valid, e_line_bit, e_line_ready;
    logic [15:0] ml = 16'h0000;
    logic [15:0] el = 16'h0000;
    logic [2:0] cyc = 3'h0;
    int taken = 0;
    int num_errors = 0;
    int total_checks = 0;
    initial
    begin
        forever #20 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // design and line partners
    // ---------------------------------------------------------------
    atm_mux dut_u (.clk(clk), .rst_n(rst_n), .m_trib_valid(m_trib_valid),
        .m_trib_bit(m_bits), .m_trib_ready(m_trib_ready), .m_stuff_req(cur.ms),
        .m_alarm(cur.ma), .m_parity(cur.mp), .m_line_valid(m_line_valid),
        .m_line_bit(m_line_bit), .m_line_ready(m_line_ready),
        .e_trib_valid(e_trib_valid), .e_trib_bit({4{cur.eb}}), .e_trib_ready(e_trib_ready),
        .e_stuff_req_mid({4{cur.em}}), .e_stuff_req_top(cur.et), .e_mid_alarm(cur.ea),
        .e_mid_nat(cur.en), .e_top_alarm(cur.en), .e_top_nat(cur.ea),
        .e_line_valid(e_line_valid), .e_line_bit(e_line_bit), .e_line_ready(e_line_ready));
    atm_line_sink msink (.clk(clk), .rst_n(rst_n), .stall(cur.gap), .limit(ml),
        .line_valid(m_line_valid), .line_bit(m_line_bit), .line_ready(m_line_ready));
    atm_line_sink esink (.clk(clk), .rst_n(rst_n), .stall(cur.gap), .limit(el),
        .line_valid(e_line_valid), .line_bit(e_line_bit), .line_ready(e_line_ready));
    // tributary gaps make the framers stall on a missing bit
    always @(negedge clk)
    begin
        cyc <= cyc + 3'h1;
        m_bits <= MB ^ m_tog;
        m_trib_valid <= (cur.gap && cyc == 3'h3) ? 7'h00 : 7'h7f;
        e_trib_valid <= (cur.gap && cyc == 3'h5) ? 16'h0000 : 16'hffff;
    end
    always @(posedge clk)
    begin
        taken <= rst_n ? taken + $countones(m_trib_valid & m_trib_ready) : 0;
        // each m-frame tributary flips its bit once taken, so a lost or doubled bit shows
        m_tog <= rst_n ? m_tog ^ (m_trib_valid & m_trib_ready) : 7'h00;
    end
    // ---------------------------------------------------------------
    // reference model
    // ---------------------------------------------------------------
    // 0/1 fixed bit, 2+t a data bit of tributary t
    function automatic int m_exp(int k, logic [6:0] dec);
        int sub, blk, pos;
        sub = k / 680;
        blk = (k % 680) / 85;
        pos = k % 85;
        if (pos == 0 && blk == 0)
            return (sub < 2) ? cur.ma : (sub < 4) ? cur.mp : (sub == 5);
        if (pos == 0)
            return blk[0] ? (blk == 1 || blk == 7) : dec[sub];
        if (blk == 7 && pos == sub + 1 && dec[sub])
            return STUFF_FILL;
        return 2 + (pos - 1) % 7;
    endfunction
    // 0..3 tributary slot, 4/5 fixed 0/1, 6 alarm, 7 national
    function automatic int ef_slot(int len, int w, logic [3:0] dec);
        int set, p;
        set = w / len;
        p = w % len;
        if (set == 0)
            return (p < 10) ? 4 + ((10'h3d0 >> (9 - p)) & 1) : (p < 12) ? p - 4 : (p - 12) % 4;
        if (p < 4)
            return 4 + dec[p];
        if (set == 3 && p < 8)
            return dec[p - 4] ? 5 : p - 4;
        return (p - (set == 3 ? 8 : 4)) % 4;
    endfunction
    function automatic logic code_bit(int c, logic al, logic na);
        return (c == 6) ? al : (c == 7) ? na : (c == 5);
    endfunction
    function automatic logic mid_bit(int k);
        int c;
        c = ef_slot(E_MID_SET_LEN, k % 848, (k / 848) ? cur.em : 4'h0);
        return (c < 4) ? cur.eb[c] : code_bit(c, cur.ea, cur.en);
    endfunction
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(logic seen, logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic start(atm_row_t r, int nm, int ne);
        @(negedge clk);
        cur = r;
        rst_n = 1'b0;
        ml = 16'(nm);
        el = 16'(ne);
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic run(int nm, int ne);
        int t, c;
        int idx[4];
        int mi[7];
        t = 0;
        idx = '{0, 0, 0, 0};
        mi = '{default: 0};
        while ((msink.got.size() < nm || esink.got.size() < ne) && t < 30000)
        begin
            @(posedge clk);
            t++;
        end
        check(t < 30000, 1'b1);
        // let the stalled framers settle before the take count is read
        repeat (4) @(negedge clk);
        for (int k = 0; k < nm; k++)
        begin
            c = m_exp(k % 4760, (k / 4760) ? cur.ms : 7'h00);
            if (c < 2)
                check(msink.got[k], c[0]);
            else
            begin
                check(msink.got[k], MB[c - 2] ^ mi[c - 2][0]);
                mi[c - 2]++;
            end
        end
        for (int k = 0; k < ne; k++)
        begin
            c = ef_slot(E_TOP_SET_LEN, k % 1536, (k / 1536) ? cur.et : 4'h0);
            if (c < 4)
            begin
                check(esink.got[k], mid_bit(idx[c]));
                idx[c]++;
            end
            else
                check(esink.got[k], code_bit(c, cur.en, cur.ea));
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        foreach (rows[i])
        begin
            start(rows[i], 9520, 3072);
            run(9520, 3072);
            check(taken >= rows[i].taken && taken <= rows[i].taken + 3, 1'b1);
        end
        // reset in mid-frame, then the frame restarts at the first overhead bit
        start(rows[2], 9520, 3072);
        repeat (300) @(negedge clk);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        check(m_line_valid, 1'b0);
        check(e_line_valid, 1'b0);
        start(rows[2], 1000, 600);
        run(1000, 600);
        test_done();
    end
    initial
    begin
        #(40 * 90000);
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
